//--- design/bci_defines.vh
`ifndef BCI_DEFINES_VH
`define BCI_DEFINES_VH

// Register offsets on the plain software port
`define BCI_REG_CTRL 8'h00
`define BCI_REG_STATE 8'h04
`define BCI_REG_LINK 8'h08
`define BCI_REG_CURRENT 8'h0C
`define BCI_REG_EXTMASK 8'h10
`define BCI_REG_VECBASE 8'h14
`define BCI_REG_IRQ_STAT 8'h18
`define BCI_REG_IRQ_MASK 8'h1C

// Interrupt status bits
`define BCI_IRQ_DONE 0
`define BCI_IRQ_HOST 1
`define BCI_IRQ_RSVD 2

// Command block layout in system memory
`define BCI_BLK_BYTES 5'd16
`define BCI_OFF_OPCODE 4'h0
`define BCI_OFF_STATUS 24'h000001
`define BCI_OFF_START 4'h2
`define BCI_OFF_END 4'h5
`define BCI_OFF_DEST 4'h8
`define BCI_OFF_LINK 4'hB
`define BCI_OPC_CHAIN 7
`define BCI_OPC_INT 6
`define BCI_STATUS_DONE 8'hFF

// Reset and initial values
`define BCI_LINK_INIT 24'h000050
`define BCI_EXTMASK_INIT 8'hFF
`define BCI_VEC_BASE 8'h80
`define BCI_VEC_STEP 8'h04
`define BCI_ROM_LOW 16'h0000
`define BCI_ROM_HIGH 16'h4000
`define BCI_BOOT_FETCHES 2'd3

// Dispatch table: 32 command slots, then 8 interrupt vector slots
`define BCI_TBL_ENTRIES 6'd40
`define BCI_ATTENTION_REQUEST_SLOT 5'h0F
`define BCI_CMD_FIRST 5'h01
`define BCI_CMD_COUNT 5'd10
`define BCI_OPC_RESET 5'h01
`define BCI_OPC_SETMASK 5'h02
`define BCI_OPC_BLOCK_MOVE_CMD 5'h09
`define BCI_OPC_PAGEMOV 5'h0A

// Routine codes held in the dispatch table
`define BCI_RT_DUMMY 3'd0
`define BCI_RT_RESET 3'd1
`define BCI_RT_SETMASK 3'd2
`define BCI_RT_BLOCK_MOVE_CMD 3'd3
`define BCI_RT_PAGEMOV 3'd4
`define BCI_RT_BUILTIN 3'd5

`endif

//--- design/bci_mover.v
`timescale 1ns/1ps
module bci_mover #(
    parameter AW = 24
) (
    input wire clk_i,
    input wire arst_n_i,
    input wire start_i,
    input wire page_i,
    input wire [AW-1:0] src_i,
    input wire [AW-1:0] end_i,
    input wire [AW-1:0] dst_i,
    output wire busy_o,
    output wire done_o,
    output wire bus_req_o,
    output wire bus_we_o,
    output wire [AW-1:0] bus_addr_o,
    output wire [7:0] bus_wdata_o,
    input wire [7:0] bus_rdata_i,
    input wire bus_ack_i
);
    localparam M_IDLE = 2'd0;
    localparam M_RD = 2'd1;
    localparam M_WR = 2'd2;
    localparam M_GAP = 2'd3;

    reg [1:0] st_q;
    reg page_q;
    reg done_q;
    reg [AW-1:0] src_q;
    reg [AW-1:0] last_q;
    reg [AW-1:0] dst_q;
    reg [7:0] data_q;

    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            st_q <= M_IDLE;
            page_q <= 1'b0;
            done_q <= 1'b0;
            src_q <= {AW{1'b0}};
            last_q <= {AW{1'b0}};
            dst_q <= {AW{1'b0}};
            data_q <= 8'h00;
        end
        else
        begin
            done_q <= 1'b0;
            case (st_q)
                M_IDLE:
                    if (start_i)
                    begin
                        page_q <= page_i;
                        if (page_i)
                        begin
                            // Low address byte forced to zero, whole pages copied
                            src_q <= {src_i[AW-1:8], 8'h00};
                            dst_q <= {dst_i[AW-1:8], 8'h00};
                            last_q <= {end_i[AW-1:8], 8'hFF};
                            st_q <= M_RD;
                        end
                        else
                        begin
                            src_q <= src_i;
                            dst_q <= dst_i;
                            last_q <= end_i;
                            st_q <= (end_i < src_i) ? M_IDLE : M_RD;
                            done_q <= (end_i < src_i);
                        end
                    end
                M_RD:
                    if (bus_ack_i)
                    begin
                        data_q <= bus_rdata_i;
                        st_q <= M_WR;
                    end
                M_WR:
                    if (bus_ack_i)
                    begin
                        if (src_q == last_q)
                        begin
                            st_q <= M_IDLE;
                            done_q <= 1'b1;
                        end
                        else
                        begin
                            src_q <= src_q + 1'b1;
                            dst_q <= dst_q + 1'b1;
                            // Page moves skip the per-byte idle cycle
                            st_q <= page_q ? M_RD : M_GAP;
                        end
                    end
                default:
                    st_q <= M_RD;
            endcase
        end
    end

    assign busy_o = (st_q != M_IDLE);
    assign done_o = done_q;
    assign bus_req_o = (st_q == M_RD) || (st_q == M_WR);
    assign bus_we_o = (st_q == M_WR);
    assign bus_addr_o = (st_q == M_WR) ? dst_q : src_q;
    assign bus_wdata_o = data_q;
endmodule

//--- design/bci_core.v
`timescale 1ns/1ps
`include "bci_defines.vh"

module bci_core #(
    parameter AW = 24
) (
    input wire clk_i,
    input wire arst_n_i,
    input wire [7:0] reg_addr_i,
    input wire [31:0] reg_wdata_i,
    input wire reg_we_i,
    input wire reg_re_i,
    output reg [31:0] reg_rdata_o,
    input wire attention_request_i,
    output wire host_irq_output_o,
    output wire [7:0] ext_irq_mask_o,
    output wire [15:0] boot_rom_base_o,
    output wire sys_req_o,
    output wire sys_we_o,
    output wire [AW-1:0] sys_addr_o,
    output wire [7:0] sys_wdata_o,
    input wire [7:0] sys_rdata_i,
    input wire sys_ack_i,
    output wire irq_o
);
    localparam S_BOOT = 4'd0;
    localparam S_CLR = 4'd1;
    localparam S_INST = 4'd2;
    localparam S_IDLE = 4'd3;
    localparam S_ATTENTION_REQUEST = 4'd4;
    localparam S_FETCH = 4'd5;
    localparam S_DISP = 4'd6;
    localparam S_MOVE = 4'd7;
    localparam S_CHECK = 4'd8;
    localparam S_STAT = 4'd9;

    reg [3:0] st_q;
    reg [1:0] boot_cnt_q;
    reg [5:0] idx_q;
    reg [2:0] table_q [0:39];
    reg [7:0] command_buffer_q [0:15];
    reg [AW-1:0] link_q;
    reg [AW-1:0] cur_q;
    reg [7:0] ext_mask_q;
    reg attention_request_armed_q;
    reg host_irq_q;
    reg [2:0] irq_stat_q;
    reg [2:0] irq_mask_q;
    reg soft_init_q;
    reg [2:0] attention_request_sync_q;
    reg mv_start_q;
    reg mv_page_q;
    wire attention_request_edge;
    wire [7:0] opcode;
    wire [4:0] slot;
    wire [2:0] routine;
    wire mv_busy;
    wire mv_done;
    wire mv_req;
    wire mv_we;
    wire [AW-1:0] mv_addr;
    wire [7:0] mv_wdata;
    reg [2:0] irq_set;
    integer i;

    // Gathers a three-byte little-endian address from the command buffer
    function [AW-1:0] buf_addr;
        input [3:0] base;
        begin
            buf_addr = {command_buffer_q[base + 4'd2], command_buffer_q[base + 4'd1],
                command_buffer_q[base]};
        end
    endfunction

    // Maps a command slot number to its installed routine
    function [2:0] builtin_routine;
        input [4:0] opc;
        begin
            case (opc)
                `BCI_OPC_RESET: builtin_routine = `BCI_RT_RESET;
                `BCI_OPC_SETMASK: builtin_routine = `BCI_RT_SETMASK;
                `BCI_OPC_BLOCK_MOVE_CMD: builtin_routine = `BCI_RT_BLOCK_MOVE_CMD;
                `BCI_OPC_PAGEMOV: builtin_routine = `BCI_RT_PAGEMOV;
                default: builtin_routine = `BCI_RT_BUILTIN;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Attention pin synchroniser and rising edge
    always @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            attention_request_sync_q <= 3'b000;
        end
        else
        begin
            attention_request_sync_q <= {attention_request_sync_q[1:0], attention_request_i};
        end
    end

    assign attention_request_edge = attention_request_sync_q[1] & ~attention_request_sync_q[2];

    assign opcode = command_buffer_q[`BCI_OFF_OPCODE];
    assign slot = opcode[4:0];
    // Slot of the attention jump is turned into a no-op
    assign routine = (slot == `BCI_ATTENTION_REQUEST_SLOT) ? `BCI_RT_DUMMY : table_q[slot];

    ////////////////////////////////////////////////////////////////////////
    // Interpreter sequence
    always @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            st_q <= S_BOOT;
            boot_cnt_q <= 2'd0;
            idx_q <= 6'd0;
            link_q <= `BCI_LINK_INIT;
            cur_q <= {AW{1'b0}};
            ext_mask_q <= `BCI_EXTMASK_INIT;
            attention_request_armed_q <= 1'b0;
            host_irq_q <= 1'b0;
            mv_start_q <= 1'b0;
            mv_page_q <= 1'b0;
            for (i = 0; i < 40; i = i + 1)
                table_q[i] <= `BCI_RT_DUMMY;
            for (i = 0; i < 16; i = i + 1)
                command_buffer_q[i] <= 8'h00;
        end
        else
        begin
            mv_start_q <= 1'b0;
            case (st_q)
                S_BOOT:
                begin
                    boot_cnt_q <= boot_cnt_q + 1'b1;
                    if (boot_cnt_q == `BCI_BOOT_FETCHES - 2'd1)
                    begin
                        st_q <= S_CLR;
                    end
                    idx_q <= 6'd0;
                end
                S_CLR:
                begin
                    ext_mask_q <= `BCI_EXTMASK_INIT;
                    attention_request_armed_q <= 1'b0;
                    table_q[idx_q] <= `BCI_RT_DUMMY;
                    idx_q <= idx_q + 1'b1;
                    if (idx_q == `BCI_TBL_ENTRIES - 6'd1)
                    begin
                        idx_q <= {1'b0, `BCI_CMD_FIRST};
                        st_q <= S_INST;
                    end
                end
                S_INST:
                begin
                    table_q[idx_q] <= builtin_routine(idx_q[4:0]);
                    idx_q <= idx_q + 1'b1;
                    if (idx_q[4:0] == `BCI_CMD_FIRST + `BCI_CMD_COUNT - 5'd1)
                    begin
                        link_q <= `BCI_LINK_INIT;
                        attention_request_armed_q <= 1'b1;
                        st_q <= S_IDLE;
                    end
                end
                S_IDLE:
                    if (attention_request_armed_q && attention_request_edge)
                    begin
                        st_q <= S_ATTENTION_REQUEST;
                    end
                S_ATTENTION_REQUEST:
                begin
                    host_irq_q <= 1'b0;
                    attention_request_armed_q <= 1'b0;
                    cur_q <= link_q;
                    idx_q <= 6'd0;
                    st_q <= S_FETCH;
                end
                S_FETCH:
                    if (sys_ack_i)
                    begin
                        command_buffer_q[idx_q[3:0]] <= sys_rdata_i;
                        idx_q <= idx_q + 1'b1;
                        if (idx_q == {1'b0, `BCI_BLK_BYTES} - 6'd1)
                        begin
                            st_q <= S_DISP;
                        end
                    end
                S_DISP:
                begin
                    link_q <= buf_addr(`BCI_OFF_LINK);
                    st_q <= S_CHECK;
                    case (routine)
                        `BCI_RT_RESET:
                        begin
                            idx_q <= 6'd0;
                            st_q <= S_CLR;
                        end
                        `BCI_RT_SETMASK:
                            ext_mask_q <= command_buffer_q[`BCI_OFF_START];
                        `BCI_RT_BLOCK_MOVE_CMD:
                        begin
                            mv_start_q <= 1'b1;
                            mv_page_q <= 1'b0;
                            st_q <= S_MOVE;
                        end
                        `BCI_RT_PAGEMOV:
                        begin
                            mv_start_q <= 1'b1;
                            mv_page_q <= 1'b1;
                            st_q <= S_MOVE;
                        end
                        default:
                            st_q <= S_CHECK;
                    endcase
                end
                S_MOVE:
                    if (mv_done)
                    begin
                        st_q <= S_CHECK;
                    end
                S_CHECK:
                    st_q <= opcode[`BCI_OPC_CHAIN] ? S_ATTENTION_REQUEST : S_STAT;
                S_STAT:
                    if (sys_ack_i)
                    begin
                        host_irq_q <= opcode[`BCI_OPC_INT];
                        attention_request_armed_q <= 1'b1;
                        st_q <= S_IDLE;
                    end
                default:
                    st_q <= S_IDLE;
            endcase
            // Software re-initialisation starts the table clear again
            if (soft_init_q)
            begin
                idx_q <= 6'd0;
                host_irq_q <= 1'b0;
                st_q <= S_CLR;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Copy engine
    bci_mover #(
        .AW(AW)
    ) u_mover (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .start_i(mv_start_q),
        .page_i(mv_page_q),
        .src_i(buf_addr(`BCI_OFF_START)),
        .end_i(buf_addr(`BCI_OFF_END)),
        .dst_i(buf_addr(`BCI_OFF_DEST)),
        .busy_o(mv_busy),
        .done_o(mv_done),
        .bus_req_o(mv_req),
        .bus_we_o(mv_we),
        .bus_addr_o(mv_addr),
        .bus_wdata_o(mv_wdata),
        .bus_rdata_i(sys_rdata_i),
        .bus_ack_i(sys_ack_i)
    );

    // Bus shared between fetch, status write and the copy engine
    assign sys_req_o = (st_q == S_FETCH) || (st_q == S_STAT) || ((st_q == S_MOVE) && mv_req);
    assign sys_we_o = (st_q == S_STAT) || ((st_q == S_MOVE) && mv_we);
    assign sys_addr_o = (st_q == S_MOVE) ? mv_addr :
        (st_q == S_STAT) ? cur_q + `BCI_OFF_STATUS : cur_q + {{(AW-6){1'b0}}, idx_q};
    assign sys_wdata_o = (st_q == S_MOVE) ? mv_wdata : `BCI_STATUS_DONE;

    assign host_irq_output_o = host_irq_q;
    assign ext_irq_mask_o = ext_mask_q;
    assign boot_rom_base_o = (st_q == S_BOOT) ? `BCI_ROM_LOW : `BCI_ROM_HIGH;

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status and software port
    always @*
    begin
        irq_set = 3'b000;
        irq_set[`BCI_IRQ_DONE] = (st_q == S_STAT) && sys_ack_i;
        irq_set[`BCI_IRQ_HOST] = (st_q == S_STAT) && sys_ack_i && opcode[`BCI_OPC_INT];
        irq_set[`BCI_IRQ_RSVD] = (st_q == S_DISP) && (slot == `BCI_ATTENTION_REQUEST_SLOT);
    end

    always @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            irq_stat_q <= 3'b000;
            irq_mask_q <= 3'b000;
            soft_init_q <= 1'b0;
            reg_rdata_o <= 32'h00000000;
        end
        else
        begin
            soft_init_q <= reg_we_i && (reg_addr_i == `BCI_REG_CTRL) && reg_wdata_i[0];
            // New events win over a same-cycle clear
            if (reg_we_i && (reg_addr_i == `BCI_REG_IRQ_STAT))
                irq_stat_q <= (irq_stat_q & ~reg_wdata_i[2:0]) | irq_set;
            else
                irq_stat_q <= irq_stat_q | irq_set;
            if (reg_we_i && (reg_addr_i == `BCI_REG_IRQ_MASK))
                irq_mask_q <= reg_wdata_i[2:0];
            reg_rdata_o <= 32'h00000000;
            if (reg_re_i)
            begin
                case (reg_addr_i)
                    `BCI_REG_STATE:
                        reg_rdata_o <= {20'h00000, mv_busy, host_irq_q, attention_request_armed_q,
                            opcode[4:0], st_q};
                    `BCI_REG_LINK: reg_rdata_o <= {{(32-AW){1'b0}}, link_q};
                    `BCI_REG_CURRENT: reg_rdata_o <= {{(32-AW){1'b0}}, cur_q};
                    `BCI_REG_EXTMASK: reg_rdata_o <= {24'h000000, ext_mask_q};
                    `BCI_REG_VECBASE: reg_rdata_o <= {16'h0000, `BCI_VEC_STEP, `BCI_VEC_BASE};
                    `BCI_REG_IRQ_STAT: reg_rdata_o <= {29'h00000000, irq_stat_q};
                    `BCI_REG_IRQ_MASK: reg_rdata_o <= {29'h00000000, irq_mask_q};
                    default: reg_rdata_o <= 32'h00000000;
                endcase
            end
        end
    end

    assign irq_o = |(irq_stat_q & irq_mask_q);
endmodule

//--- testbench/bci_core_monitor.sv
`timescale 1ns/1ps
module bci_core_monitor #(
    parameter AW = 24
) (
    input wire clk_i,
    input wire arst_n_i,
    input wire [7:0] reg_addr_i,
    input wire reg_re_i,
    input wire [31:0] reg_rdata_o,
    input wire host_irq_output_o,
    input wire [7:0] ext_irq_mask_o,
    input wire [15:0] boot_rom_base_o,
    input wire sys_req_o,
    input wire sys_we_o,
    input wire [AW-1:0] sys_addr_o,
    input wire [7:0] sys_wdata_o,
    input wire sys_ack_i
);
    reg [7:0] cyc_q;
    reg stat_q;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    ////////////////////////////////////////////////////////////////////////////////
    // Cycles since reset release, and an accepted write of the done byte
    always @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            cyc_q <= 8'h00;
            stat_q <= 1'b0;
        end
        else
        begin
            if (cyc_q != 8'hFF)
                cyc_q <= cyc_q + 8'h01;
            stat_q <= sys_req_o & sys_we_o & sys_ack_i & (sys_wdata_o == 8'hFF);
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    property p_boot_low; cyc_q < 8'h02 |-> boot_rom_base_o == 16'h0000; endproperty
    a_boot_low: assert property (p_boot_low) else $error("boot base not low");
    property p_boot_high; cyc_q >= 8'h04 |-> boot_rom_base_o == 16'h4000; endproperty
    a_boot_high: assert property (p_boot_high) else $error("boot base not high");
    property p_boot_once; $changed(boot_rom_base_o) |-> cyc_q < 8'h05; endproperty
    a_boot_once: assert property (p_boot_once) else $error("boot base moved late");
    property p_mask_init; cyc_q < 8'h3C |-> ext_irq_mask_o == 8'hFF; endproperty
    a_mask_init: assert property (p_mask_init) else $error("ext mask not all set");
    property p_quiet_init; cyc_q < 8'h30 |-> !sys_req_o; endproperty
    a_quiet_init: assert property (p_quiet_init) else $error("bus used during init");
    property p_irq_drop; $rose(sys_req_o) |-> !host_irq_output_o; endproperty
    a_irq_drop: assert property (p_irq_drop) else $error("host irq high on request");
    property p_irq_raise; $rose(host_irq_output_o) |-> stat_q; endproperty
    a_irq_raise: assert property (p_irq_raise) else $error("host irq without status");
    property p_bus_hold;
        sys_req_o && !sys_ack_i |=> sys_req_o && $stable(sys_addr_o) && $stable(sys_we_o)
            && $stable(sys_wdata_o);
    endproperty
    a_bus_hold: assert property (p_bus_hold) else $error("bus request dropped");
    property p_vec_read; reg_re_i && reg_addr_i == 8'h14 |=> reg_rdata_o == 32'h480; endproperty
    a_vec_read: assert property (p_vec_read) else $error("vector base wrong");
    property p_mask_read;
        reg_re_i && reg_addr_i == 8'h10 |=> reg_rdata_o == {24'h0, $past(ext_irq_mask_o)};
    endproperty
    a_mask_read: assert property (p_mask_read) else $error("mask readback wrong");
endmodule

bind bci_core bci_core_monitor #(.AW(AW)) mon_u (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i), .reg_re_i(reg_re_i),
    .reg_rdata_o(reg_rdata_o), .host_irq_output_o(host_irq_output_o),
    .ext_irq_mask_o(ext_irq_mask_o), .boot_rom_base_o(boot_rom_base_o), .sys_req_o(sys_req_o),
    .sys_we_o(sys_we_o), .sys_addr_o(sys_addr_o), .sys_wdata_o(sys_wdata_o), .sys_ack_i(sys_ack_i)
);

//--- testbench/bci_sysmem.sv
`timescale 1ns/1ps
module bci_sysmem (
    input wire clk_i,
    input wire arst_n_i,
    input wire [1:0] wait_i,
    input wire req_i,
    input wire we_i,
    input wire [23:0] addr_i,
    input wire [7:0] wdata_i,
    output reg [7:0] rdata_o,
    output reg ack_o
);
    reg [7:0] mem [0:65535];
    reg [1:0] cnt_q;
    // Ack after wait_i stall cycles; read data toggles outside a read ack
    always @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            ack_o <= 1'b0;
            cnt_q <= 2'h0;
            rdata_o <= 8'h00;
        end
        else
        begin
            ack_o <= 1'b0;
            rdata_o <= ~rdata_o;
            if (req_i && !ack_o && cnt_q == wait_i)
            begin
                ack_o <= 1'b1;
                cnt_q <= 2'h0;
                if (we_i)
                    mem[addr_i[15:0]] <= wdata_i;
                else
                    rdata_o <= mem[addr_i[15:0]];
            end
            else if (req_i && !ack_o)
                cnt_q <= cnt_q + 2'h1;
        end
    end
endmodule

//--- testbench/bus_command_interpreter_tb_top.sv
`timescale 1ns/1ps
module bus_command_interpreter_tb_top;
    typedef struct {
        logic [7:0] opc;
        logic [23:0] s;
        logic [23:0] e;
        logic [23:0] d;
    } bci_row_t;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0;
    logic reg_we_i = 1'b0;
    logic reg_re_i = 1'b0;
    logic attention_request_i = 1'b0;
    logic [1:0] wait_q = 2'h0;
    wire [31:0] reg_rdata_o;
    wire [7:0] ext_irq_mask_o, sys_wdata_o, sys_rdata_i;
    wire [15:0] boot_rom_base_o;
    wire [23:0] sys_addr_o;
    wire host_irq_output_o, sys_req_o, sys_we_o, sys_ack_i, irq_o;
    int errors = 0;
    int n_checks = 0;
    int cyc = 0;
    // Empty slot, block move with bit 5 set, whole-page move, reserved, set mask, built-in
    bci_row_t rows [6] = '{'{8'h00, 24'h0, 24'h0, 24'h0},
        '{8'h69, 24'h001003, 24'h001012, 24'h002001},
        '{8'h0A, 24'h001100, 24'h0011FF, 24'h003000},
        '{8'h4F, 24'h0, 24'h0, 24'h0}, '{8'h42, 24'h00005A, 24'h0, 24'h0},
        '{8'h05, 24'h0, 24'h0, 24'h0}};
    bci_core dut_u (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
        .attention_request_i(attention_request_i), .host_irq_output_o(host_irq_output_o),
        .ext_irq_mask_o(ext_irq_mask_o), .boot_rom_base_o(boot_rom_base_o), .sys_req_o(sys_req_o),
        .sys_we_o(sys_we_o), .sys_addr_o(sys_addr_o), .sys_wdata_o(sys_wdata_o),
        .sys_rdata_i(sys_rdata_i), .sys_ack_i(sys_ack_i), .irq_o(irq_o)
    );
    bci_sysmem mem_u (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .wait_i(wait_q), .req_i(sys_req_o), .we_i(sys_we_o),
        .addr_i(sys_addr_o), .wdata_i(sys_wdata_o), .rdata_o(sys_rdata_i), .ack_o(sys_ack_i)
    );
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            errors++;
            $display("Error at %0t: run timed out", $time);
            summarize();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task summarize();
        $display("Checks %0d, errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task reg_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_i);
        reg_we_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= v;
        @(posedge clk_i);
        reg_we_i <= 1'b0;
    endtask
    task reg_rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk_i);
        reg_re_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_i);
        reg_re_i <= 1'b0;
        #1 v = reg_rdata_o;
    endtask
    task put_blk(input logic [23:0] a, input bci_row_t r, input logic [23:0] lnk);
        mem_u.mem[a[15:0]] = r.opc;
        mem_u.mem[a[15:0] + 1] = 8'h00;
        for (int k = 0; k < 3; k++)
        begin
            mem_u.mem[a[15:0] + 2 + k] = r.s[8*k +: 8];
            mem_u.mem[a[15:0] + 5 + k] = r.e[8*k +: 8];
            mem_u.mem[a[15:0] + 8 + k] = r.d[8*k +: 8];
            mem_u.mem[a[15:0] + 11 + k] = lnk[8*k +: 8];
        end
    endtask
    task wait_idle();
        logic [31:0] d;
        int k;
        d = 32'h0;
        for (k = 0; k < 4000 && !(d[3:0] == 4'h3 && d[9] === 1'b1); k++)
            reg_rd(8'h04, d);
        check(k < 4000, 1'b1);
    endtask
    task run_cmd();
        @(posedge clk_i);
        attention_request_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        attention_request_i <= 1'b0;
        wait_idle();
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        logic [31:0] d;
        logic [23:0] a, lnk, src, dst;
        int n;
        for (int k = 0; k < 65536; k++)
            mem_u.mem[k] = (k >= 4096 && k < 8192) ? 8'(k) ^ 8'hA5 : 8'h00;
        repeat (4) @(posedge clk_i);
        arst_n_i <= 1'b1;
        wait_idle();
        reg_rd(8'h08, d);
        check(d, 32'h50);
        reg_rd(8'h10, d);
        check(d, 32'hFF);
        reg_wr(8'h40, 32'hFFFFFFFF);
        reg_rd(8'h40, d);
        check(d, 32'h0);
        reg_wr(8'h1C, 32'h1);
        for (int i = 0; i < 6; i++)
        begin
            a = (i == 0) ? 24'h000050 : 24'h000100 + 24'(i * 16);
            lnk = 24'h000100 + 24'((i + 1) * 16);
            put_blk(a, rows[i], lnk);
            wait_q <= 2'(i % 3);
            reg_wr(8'h18, 32'h7);
            run_cmd();
            check(mem_u.mem[a[15:0] + 1], 8'hFF);
            check(host_irq_output_o, rows[i].opc[6]);
            check(irq_o, 1'b1);
            reg_rd(8'h18, d);
            check(d, {29'h0, rows[i].opc[4:0] == 5'h0F, rows[i].opc[6], 1'b1});
            reg_rd(8'h08, d);
            check(d, lnk);
            reg_rd(8'h0C, d);
            check(d, a);
            if (rows[i].opc[4:0] == 5'h02)
                check(ext_irq_mask_o, rows[i].s[7:0]);
            src = rows[i].s;
            dst = rows[i].d;
            n = (rows[i].opc[4:0] == 5'h09) ? int'(rows[i].e - rows[i].s) + 1 : 0;
            if (rows[i].opc[4:0] == 5'h0A)
            begin
                src[7:0] = 8'h00;
                dst[7:0] = 8'h00;
                n = (int'(rows[i].e[23:8]) - int'(rows[i].s[23:8]) + 1) * 256;
            end
            for (int k = 0; k < n; k++)
                check(mem_u.mem[dst[15:0] + k], mem_u.mem[src[15:0] + k]);
            check(mem_u.mem[dst[15:0] + n], 8'h00);
        end
        // Chained pair with the interrupt masked, status byte written by the second block only
        reg_wr(8'h1C, 32'h0);
        reg_wr(8'h18, 32'h7);
        put_blk(24'h000160, '{8'h80, 24'h0, 24'h0, 24'h0}, 24'h000170);
        put_blk(24'h000170, '{8'h40, 24'h0, 24'h0, 24'h0}, 24'h000180);
        run_cmd();
        check(mem_u.mem[16'h0161], 8'h00);
        check(mem_u.mem[16'h0171], 8'hFF);
        check(host_irq_output_o, 1'b1);
        check(irq_o, 1'b0);
        reg_rd(8'h08, d);
        check(d, 32'h180);
        // Software re-initialise, then a chained set mask into the reset command
        reg_wr(8'h00, 32'h1);
        wait_idle();
        check(host_irq_output_o, 1'b0);
        check(ext_irq_mask_o, 8'hFF);
        reg_rd(8'h08, d);
        check(d, 32'h50);
        reg_rd(8'h14, d);
        check(d, 32'h480);
        put_blk(24'h000050, '{8'hC2, 24'h00005A, 24'h0, 24'h0}, 24'h000060);
        put_blk(24'h000060, '{8'h01, 24'h0, 24'h0, 24'h0}, 24'h000777);
        run_cmd();
        check(mem_u.mem[16'h0051], 8'h00);
        check(mem_u.mem[16'h0061], 8'h00);
        check(ext_irq_mask_o, 8'hFF);
        reg_rd(8'h08, d);
        check(d, 32'h50);
        @(posedge clk_i);
        arst_n_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        check(boot_rom_base_o, 16'h0000);
        check(host_irq_output_o, 1'b0);
        arst_n_i <= 1'b1;
        wait_idle();
        check(boot_rom_base_o, 16'h4000);
        reg_rd(8'h08, d);
        check(d, 32'h50);
        summarize();
    end
endmodule
